// ===== hdl/bwc_pkg.sv
// Functional notes
// - working wrap bit 0 enables, 1 disables
// - length code 00..11 gives 16..128 bytes
// - wrap only for quad and DDR quad reads
// - any reset loads working wrap bit from boot
// - any reset loads working length from boot
// - boot drive field 7:5 loads working drive
// - working drive writable, takes effect at once
// - register read/write and burst-length commands supported
// - wrap disabled means plain sequential addressing
// - non-array reads ignore the wrap setting
`default_nettype none
package bwc_pkg;

  // ----------------------------------------------------------------
  // configuration byte layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] drive;      // output drive strength code
    logic       wrap_dis;   // 1 = wrap disabled
    logic [1:0] rsvd;       // reserved, always zero
    logic [1:0] wrap_len;   // wrap length code
  } bwc_cfg_t;

  // boot copy power-on value: drive 000, wrap disabled, 16 bytes
  localparam bwc_cfg_t BOOT_RESET = 8'h10;

  // field positions inside the byte
  localparam int DRIVE_LSB    = 5;
  localparam int WRAP_DIS_BIT = 4;
  localparam int WRAP_LEN_LSB = 0;

  // ----------------------------------------------------------------
  // serial commands and register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_RD_ANY    = 8'h65;
  localparam logic [7:0]  CMD_WR_ANY    = 8'h71;
  localparam logic [7:0]  CMD_SET_BURST = 8'hC0;
  localparam logic [23:0] ADDR_BOOT_CFG = 24'h000010;
  localparam logic [23:0] ADDR_WORK_CFG = 24'h000011;
  localparam int          CMD_BITS      = 8;
  localparam int          ADDR_BITS     = 24;

  // read commands that honour the wrap setting
  localparam logic [7:0]  QUAD_RD_CMD     = 8'hA1;
  localparam logic [7:0]  DDR_QUAD_RD_CMD = 8'hA2;

  // ----------------------------------------------------------------
  // serial engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_DIN, ST_DOUT, ST_IGNORE
  } bwc_state_t;

  // low-address mask of the wrap block for a length code
  function automatic logic [6:0] wrap_mask(input logic [1:0] code);
    logic [6:0] m;
    m = 7'h0F;
    case (code)
      2'h0:    m = 7'h0F;
      2'h1:    m = 7'h1F;
      2'h2:    m = 7'h3F;
      default: m = 7'h7F;
    endcase
    return m;
  endfunction : wrap_mask

  // reserved bits never store a one
  function automatic bwc_cfg_t clean_cfg(input logic [7:0] b);
    bwc_cfg_t c;
    c      = b;
    c.rsvd = 2'h0;
    return c;
  endfunction : clean_cfg

endpackage : bwc_pkg
`default_nettype wire

// ===== hdl/bwc_addr_seq.sv
`timescale 1ns/1ps
`default_nettype none
module bwc_addr_seq #(
  parameter logic [7:0] QUAD_CMD = bwc_pkg::QUAD_RD_CMD,
  parameter logic [7:0] DDR_CMD  = bwc_pkg::DDR_QUAD_RD_CMD
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic             start,    // new read begins
  input  wire logic [7:0]       cmd,      // read command code
  input  wire logic             main,     // read targets main array
  input  wire logic [31:0]      addr_in,  // first byte address
  input  wire logic             adv,      // one byte consumed
  input  wire bwc_pkg::bwc_cfg_t cfg,     // working configuration
  output logic [31:0]           addr_r,   // current byte address
  output logic                  wrap_r    // burst runs wrapped
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] addr_nxt;  // next byte address
  logic        wrap_nxt;  // next wrap mode
  logic [6:0]  mask_r;    // block mask latched at start
  logic [6:0]  mask_nxt;
  logic        is_quad;   // command is one of the two quad reads

  // mode fixed at start so a mid-burst write cannot tear a burst
  always_comb begin
    is_quad  = (cmd == QUAD_CMD) || (cmd == DDR_CMD);
    addr_nxt = addr_r;
    wrap_nxt = wrap_r;
    mask_nxt = mask_r;
    if (start) begin
      addr_nxt = addr_in;
      wrap_nxt = main && is_quad && !cfg.wrap_dis;
      mask_nxt = bwc_pkg::wrap_mask(cfg.wrap_len);
    end else if (adv) begin
      if (wrap_r) begin
        // roll within the aligned block
        addr_nxt = {addr_r[31:7],
                    (addr_r[6:0] & ~mask_r) | ((addr_r[6:0] + 7'h01) & mask_r)};
      end else begin
        addr_nxt = addr_r + 32'h0000_0001;
      end
    end
  end

  // registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_r <= 32'h0000_0000;
      wrap_r <= 1'b0;
      mask_r <= 7'h0F;
    end else if (ce) begin
      addr_r <= addr_nxt;
      wrap_r <= wrap_nxt;
      mask_r <= mask_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_wrap_in_block: assert property (ce && adv && wrap_r && !start |=>
      ((addr_r[6:0] & ~mask_r) == ($past(addr_r[6:0]) & ~mask_r)) &&
      ((addr_r[6:0] & mask_r) == (($past(addr_r[6:0]) + 7'h01) & mask_r)))
    else $error("wrapped address left its block");
  a_seq_linear: assert property (ce && adv && !wrap_r && !start |=>
      addr_r == $past(addr_r) + 32'h0000_0001)
    else $error("linear address did not step by one");
  a_other_cmd: assert property (ce && start && cmd != QUAD_CMD && cmd != DDR_CMD
      |=> !wrap_r)
    else $error("wrap applied to other read");
  a_non_array: assert property (ce && start && !main |=> !wrap_r)
    else $error("wrap applied outside main array");
  a_wrap_enter: assert property (ce && start && main && is_quad
      |=> wrap_r == !$past(cfg.wrap_dis))
    else $error("wrap mode does not follow enable bit");
  a_len_mask: assert property (ce && start
      |=> mask_r == 7'((8'h10 << $past(cfg.wrap_len)) - 8'h01))
    else $error("wrap length mask wrong");

endmodule : bwc_addr_seq
`default_nettype wire

// ===== hdl/bwc_config.sv
`timescale 1ns/1ps
`default_nettype none
module bwc_config #(
  parameter logic [7:0] QUAD_CMD = bwc_pkg::QUAD_RD_CMD,
  parameter logic [7:0] DDR_CMD  = bwc_pkg::DDR_QUAD_RD_CMD
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  // serial link pins, asynchronous to clk
  input  wire logic              sck_i,
  input  wire logic              cs_n_i,
  input  wire logic              si_i,
  output logic                   so_o,
  output logic                   so_oe_o,
  // software reset from the command decoder, same clock
  input  wire logic              sw_reset_i,
  // read engine side, same clock
  input  wire logic              rd_start_i,
  input  wire logic [7:0]        rd_cmd_i,
  input  wire logic              rd_main_i,
  input  wire logic [31:0]       rd_addr_i,
  input  wire logic              rd_adv_i,
  output logic [31:0]            rd_addr_o,
  output logic                   rd_wrap_o,
  // configuration presented to the device
  output bwc_pkg::bwc_cfg_t      working_cfg_o,
  output bwc_pkg::bwc_cfg_t      boot_cfg_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sck_q;   // sck two-stage chain
  logic [1:0] cs_q;    // chip select chain
  logic [1:0] si_q;    // data in chain
  logic       sck_d;   // delayed second stage for edges
  logic       sck_s;   // synchronised sck
  logic       cs_s;    // synchronised chip select, high = idle
  logic       si_s;    // synchronised data in
  logic       rise;    // sck rising edge seen
  logic       fall;    // sck falling edge seen

  // chip select resets high so nothing starts before a real frame
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_q <= 2'h0;
      cs_q  <= 2'h3;
      si_q  <= 2'h0;
      sck_d <= 1'b0;
    end else if (ce) begin
      sck_q <= {sck_q[0], sck_i};
      cs_q  <= {cs_q[0], cs_n_i};
      si_q  <= {si_q[0], si_i};
      sck_d <= sck_q[1];
    end
  end

  // only the second stage is looked at by logic
  always_comb begin
    sck_s = sck_q[1];
    cs_s  = cs_q[1];
    si_s  = si_q[1];
    rise  = sck_s && !sck_d;
    fall  = !sck_s && sck_d;
  end

  // ----------------------------------------------------------------
  // serial engine and configuration registers
  // ----------------------------------------------------------------
  bwc_pkg::bwc_state_t st_r, st_nxt;       // engine state
  logic [4:0]          cnt_r, cnt_nxt;     // bit counter
  logic [7:0]          sh_r, sh_nxt;       // input shifter
  logic [7:0]          cmd_r, cmd_nxt;     // latched command
  logic [23:0]         addr_r, addr_nxt;   // register address
  logic [7:0]          osh_r, osh_nxt;     // output shifter
  logic                so_nxt;             // next data out
  logic                oe_nxt;             // next output enable
  bwc_pkg::bwc_cfg_t   boot_r, boot_nxt;   // persistent copy
  bwc_pkg::bwc_cfg_t   work_r, work_nxt;   // working copy
  logic [7:0]          byte_in;            // byte completed this edge
  logic                wr_work_hit;        // generic write to working copy
  logic                burst_set_hit;      // burst-length write
  logic                wr_boot_hit;        // generic write to boot copy

  // register read view; unmapped addresses read zero
  function automatic logic [7:0] reg_view(input logic [23:0] a,
                                          input bwc_pkg::bwc_cfg_t bt,
                                          input bwc_pkg::bwc_cfg_t wk);
    logic [7:0] v;
    v = 8'h00;
    if (a == bwc_pkg::ADDR_BOOT_CFG) begin
      v = bt;
    end else if (a == bwc_pkg::ADDR_WORK_CFG) begin
      v = wk;
    end
    return v;
  endfunction : reg_view

  // next-state logic; one byte payload for writes, repeat on reads
  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    sh_nxt      = sh_r;
    cmd_nxt     = cmd_r;
    addr_nxt    = addr_r;
    osh_nxt     = osh_r;
    boot_nxt    = boot_r;
    work_nxt    = work_r;
    byte_in     = {sh_r[6:0], si_s};
    wr_work_hit = 1'b0;
    burst_set_hit = 1'b0;
    wr_boot_hit = 1'b0;
    if (cs_s) begin
      // deselected: abandon any partial command
      st_nxt  = bwc_pkg::ST_IDLE;
      cnt_nxt = 5'h00;
    end else begin
      case (st_r)
        bwc_pkg::ST_IDLE: begin
          st_nxt  = bwc_pkg::ST_CMD;
          cnt_nxt = 5'h00;
        end
        bwc_pkg::ST_CMD: begin
          if (rise) begin
            sh_nxt  = byte_in;
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == 5'(bwc_pkg::CMD_BITS - 1)) begin
              cmd_nxt = byte_in;
              cnt_nxt = 5'h00;
              // decode of supported commands
              if (byte_in == bwc_pkg::CMD_RD_ANY || byte_in == bwc_pkg::CMD_WR_ANY) begin
                st_nxt = bwc_pkg::ST_ADDR;
              end else if (byte_in == bwc_pkg::CMD_SET_BURST) begin
                st_nxt = bwc_pkg::ST_DIN;
              end else begin
                st_nxt = bwc_pkg::ST_IGNORE;
              end
            end
          end
        end
        bwc_pkg::ST_ADDR: begin
          if (rise) begin
            addr_nxt = {addr_r[22:0], si_s};
            cnt_nxt  = cnt_r + 5'h01;
            if (cnt_r == 5'(bwc_pkg::ADDR_BITS - 1)) begin
              cnt_nxt = 5'h00;
              if (cmd_r == bwc_pkg::CMD_RD_ANY) begin
                st_nxt  = bwc_pkg::ST_DOUT;
                osh_nxt = reg_view({addr_r[22:0], si_s}, boot_r, work_r);
              end else begin
                st_nxt = bwc_pkg::ST_DIN;
              end
            end
          end
        end
        bwc_pkg::ST_DIN: begin
          if (rise) begin
            sh_nxt  = byte_in;
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == 5'(bwc_pkg::CMD_BITS - 1)) begin
              st_nxt = bwc_pkg::ST_IGNORE;
              if (cmd_r == bwc_pkg::CMD_SET_BURST) begin
                // burst length touches only the wrap fields
                burst_set_hit     = 1'b1;
                work_nxt.wrap_dis = byte_in[bwc_pkg::WRAP_DIS_BIT];
                work_nxt.wrap_len = byte_in[bwc_pkg::WRAP_LEN_LSB +: 2];
              end else if (addr_r == bwc_pkg::ADDR_WORK_CFG) begin
                // drive code acts on the pads right away
                wr_work_hit = 1'b1;
                work_nxt    = bwc_pkg::clean_cfg(byte_in);
              end else if (addr_r == bwc_pkg::ADDR_BOOT_CFG) begin
                wr_boot_hit = 1'b1;
                boot_nxt    = bwc_pkg::clean_cfg(byte_in);
              end
            end
          end
        end
        bwc_pkg::ST_DOUT: begin
          // rises count bits, falls present the next bit
          if (rise) begin
            cnt_nxt = {2'h0, cnt_r[2:0] + 3'h1};
          end
          if (fall) begin
            if (cnt_r[2:0] == 3'h0) begin
              osh_nxt = reg_view(addr_r, boot_r, work_r);
            end else begin
              osh_nxt = {osh_r[6:0], 1'b0};
            end
          end
        end
        default: begin
          st_nxt = st_r;  // ignore until deselect
        end
      endcase
    end
    // software reset reloads the working copy and wins over a write
    if (sw_reset_i) begin
      work_nxt = boot_r;
    end
    so_nxt = (st_nxt == bwc_pkg::ST_DOUT) ? osh_nxt[7] : 1'b0;
    oe_nxt = (st_nxt == bwc_pkg::ST_DOUT);
  end

  // registers; hardware reset puts both copies at the boot value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r    <= bwc_pkg::ST_IDLE;
      cnt_r   <= 5'h00;
      sh_r    <= 8'h00;
      cmd_r   <= 8'h00;
      addr_r  <= 24'h000000;
      osh_r   <= 8'h00;
      so_o    <= 1'b0;
      so_oe_o <= 1'b0;
      boot_r  <= bwc_pkg::BOOT_RESET;
      work_r  <= bwc_pkg::BOOT_RESET;
    end else if (ce) begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      cmd_r   <= cmd_nxt;
      addr_r  <= addr_nxt;
      osh_r   <= osh_nxt;
      so_o    <= so_nxt;
      so_oe_o <= oe_nxt;
      boot_r  <= boot_nxt;
      work_r  <= work_nxt;
    end
  end

  // configuration straight from the two flops
  always_comb begin
    working_cfg_o = work_r;
    boot_cfg_o    = boot_r;
  end

  // ----------------------------------------------------------------
  // read address sequencer
  // ----------------------------------------------------------------
  bwc_addr_seq #(
    .QUAD_CMD (QUAD_CMD),
    .DDR_CMD  (DDR_CMD)
  ) u_seq (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .start   (rd_start_i),
    .cmd     (rd_cmd_i),
    .main    (rd_main_i),
    .addr_in (rd_addr_i),
    .adv     (rd_adv_i),
    .cfg     (work_r),
    .addr_r  (rd_addr_o),
    .wrap_r  (rd_wrap_o)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_soft_reset;
    ce && sw_reset_i;
  endsequence
  sequence s_burst_set;
    ce && burst_set_hit && !sw_reset_i;
  endsequence
  // cycles in which neither a command nor a reset may touch the working copy
  sequence s_work_quiet;
    ce && !wr_work_hit && !burst_set_hit && !sw_reset_i;
  endsequence
  // device sees its select released
  sequence s_deselect;
    ce && cs_s;
  endsequence

  a_soft_wrap_en: assert property (s_soft_reset |=> work_r.wrap_dis == $past(boot_r.wrap_dis))
    else $error("wrap enable not reloaded from boot copy");
  a_soft_wrap_len: assert property (s_soft_reset |=> work_r.wrap_len == $past(boot_r.wrap_len))
    else $error("wrap length not reloaded from boot copy");
  a_soft_drive: assert property (s_soft_reset |=> working_cfg_o.drive == $past(boot_r.drive))
    else $error("drive code not reloaded from boot copy");
  a_drive_write: assert property (ce && wr_work_hit && !sw_reset_i
      |=> working_cfg_o.drive == $past(byte_in[bwc_pkg::DRIVE_LSB +: 3]))
    else $error("drive code write did not take effect");
  a_burst_wr: assert property (s_burst_set |=> work_r.wrap_len == $past(byte_in[1:0])
      && work_r.wrap_dis == $past(byte_in[4]) && work_r.drive == $past(work_r.drive))
    else $error("burst length write wrong");
  a_boot_hold: assert property (ce && !wr_boot_hit |=> boot_r == $past(boot_r))
    else $error("boot copy changed without a write");
  // a stray update here would retune the pads behind the host's back
  a_work_hold: assert property (s_work_quiet |=> work_r == $past(work_r))
    else $error("working copy changed without a command");
  // a deselected device must let go of its data pin
  a_oe_release: assert property (s_deselect |=> !so_oe_o)
    else $error("data pin still driven while deselected");
  // reserved bits are never stored, so they always read back as zero
  a_rsvd_clear: assert property (ce |=> work_r.rsvd == 2'h0 && boot_r.rsvd == 2'h0)
    else $error("reserved bit stored in a configuration copy");

endmodule : bwc_config
`default_nettype wire

// ===== tb/bwc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// serial host model: mode 0, msb first, 160 ns link clock
// ----------------------------------------------------------------
module bwc_host_model (
  output logic      sck,   // link clock, parked low outside frames
  output logic      cs_n,  // select, active low
  output logic      si,    // data towards the device
  input  wire logic so,    // data from the device
  input  wire logic so_oe  // device drives so
);
  localparam int HALF = 80;  // half link period in ns

  // idle state; offset keeps link edges away from clk edges
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // one bit: data set while clock low, device takes it on the rise
  task automatic put_bit(input logic b);
    si = b;
    #HALF sck = 1'b1;
    #HALF sck = 1'b0;
  endtask : put_bit

  // opens a frame, shifts command and optional 24-bit address
  task automatic head(input logic [7:0] cmd, input logic use_addr, input logic [23:0] addr);
    #1.3 cs_n = 1'b0;
    #HALF;
    for (int i = 7; i >= 0; i--) put_bit(cmd[i]);
    if (use_addr) begin
      for (int i = 23; i >= 0; i--) put_bit(addr[i]);
    end
  endtask : head

  // closes a frame; released data line flips so a stale bit never passes as valid
  task automatic tail();
    cs_n = 1'b1;
    si   = ~si;
    #(HALF * 2);
  endtask : tail

  // register write: command, address, one data byte
  task automatic wr_reg(input logic [23:0] addr, input logic [7:0] d);
    head(bwc_pkg::CMD_WR_ANY, 1'b1, addr);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    tail();
  endtask : wr_reg

  // burst-length command: no address, one data byte
  task automatic set_burst(input logic [7:0] d);
    head(bwc_pkg::CMD_SET_BURST, 1'b0, 24'h000000);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    tail();
  endtask : set_burst

  // register read: data sampled on each rise, enable must hold all byte
  task automatic rd_reg(input logic [23:0] addr, output logic [7:0] d, output logic oe);
    head(bwc_pkg::CMD_RD_ANY, 1'b1, addr);
    oe = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      si = ~si;
      #HALF sck = 1'b1;
      d[i] = so;
      oe   = oe & so_oe;
      #HALF sck = 1'b0;
    end
    tail();
  endtask : rd_reg
endmodule : bwc_host_model
`default_nettype wire

// ===== tb/test_burst_wrap_config_register.sv
`timescale 1ns/1ps
`default_nettype none
module test_burst_wrap_config_register;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic              clk, rstn, ce, sw_reset_i;  // clock, resets, enable
  logic              rd_start_i, rd_main_i, rd_adv_i;
  logic [7:0]        rd_cmd_i;
  logic [31:0]       rd_addr_i, rd_addr_o;
  logic              rd_wrap_o;
  logic              sck, cs_n, si, so, so_oe;   // link pins
  bwc_pkg::bwc_cfg_t working_cfg, boot_cfg;
  int                err_count, total_checks;
  logic [7:0]        rd_byte;                    // byte read over the link
  logic              rd_oe;                      // enable held over the byte

  bwc_config dut (
    .clk(clk), .rstn(rstn), .ce(ce), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .so_o(so), .so_oe_o(so_oe), .sw_reset_i(sw_reset_i), .rd_start_i(rd_start_i),
    .rd_cmd_i(rd_cmd_i), .rd_main_i(rd_main_i), .rd_addr_i(rd_addr_i),
    .rd_adv_i(rd_adv_i), .rd_addr_o(rd_addr_o), .rd_wrap_o(rd_wrap_o),
    .working_cfg_o(working_cfg), .boot_cfg_o(boot_cfg)
  );
  bwc_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

  // ----------------------------------------------------------------
  // clock, watchdog and reporting
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // whole run is 6 frames of about 7 us and 9 of about 3 us; generous margin
  initial begin
    #400000;
    err_count++;
    $display("[FAIL] watchdog expected end seen timeout");
    stop_test();
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, err_count);
  endtask : end_test

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // read sequencer drivers
  // ----------------------------------------------------------------
  task automatic seq_start(input logic [7:0] cmd, input logic main, input logic [31:0] a);
    @(posedge clk);
    rd_cmd_i   <= cmd;
    rd_main_i  <= main;
    rd_addr_i  <= a;
    rd_start_i <= 1'b1;
    @(posedge clk);
    rd_start_i <= 1'b0;
    #1;
  endtask : seq_start

  task automatic seq_adv();
    @(posedge clk);
    rd_adv_i <= 1'b1;
    @(posedge clk);
    rd_adv_i <= 1'b0;
    #1;
  endtask : seq_adv

  // start one byte before the block end so the second step shows rollover
  task automatic wrap_case(input logic [7:0] cmd, input logic main, input logic [1:0] code,
                           input logic dis, input logic exp_wrap);
    logic [31:0] m, a, e;
    m = (32'h10 << code) - 32'h1;
    a = 32'h0001_2300 | (m - 32'h1);
    host.set_burst({3'h0, dis, 2'h0, code});
    chk("wrap fields", {27'h0, dis, 2'h0, code}, {27'h0, working_cfg[4:0]});
    seq_start(cmd, main, a);
    chk("wrap flag", {31'h0, exp_wrap}, {31'h0, rd_wrap_o});
    chk("first addr", a, rd_addr_o);
    for (int k = 1; k <= 3; k++) begin
      seq_adv();
      e = exp_wrap ? ((a & ~m) | ((a + k) & m)) : (a + k);
      chk("next addr", e, rd_addr_o);
    end
  endtask : wrap_case

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0; ce = 1'b1; sw_reset_i = 1'b0; rd_start_i = 1'b0; rd_main_i = 1'b0;
    rd_adv_i = 1'b0; rd_cmd_i = 8'h00; rd_addr_i = 32'h0; err_count = 0; total_checks = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("working reset", 32'h10, {24'h0, working_cfg});
    chk("boot reset", 32'h10, {24'h0, boot_cfg});
    chk("idle oe", 32'h0, {31'h0, so_oe});
    end_test("reset");
    // reserved bits dropped, drive takes effect without reset
    host.wr_reg(bwc_pkg::ADDR_WORK_CFG, 8'hEF);
    chk("working write", 32'hE3, {24'h0, working_cfg});
    host.rd_reg(bwc_pkg::ADDR_WORK_CFG, rd_byte, rd_oe);
    chk("working read", 32'hE3, {24'h0, rd_byte});
    chk("read oe", 32'h1, {31'h0, rd_oe});
    host.set_burst(8'hFE);
    chk("burst keeps drive", 32'hF2, {24'h0, working_cfg});
    end_test("working copy");
    host.wr_reg(bwc_pkg::ADDR_BOOT_CFG, 8'h43);
    chk("boot write", 32'h43, {24'h0, boot_cfg});
    chk("working untouched", 32'hF2, {24'h0, working_cfg});
    host.rd_reg(bwc_pkg::ADDR_BOOT_CFG, rd_byte, rd_oe);
    chk("boot read", 32'h43, {24'h0, rd_byte});
    @(posedge clk);
    sw_reset_i <= 1'b1;
    @(posedge clk);
    sw_reset_i <= 1'b0;
    #1;
    chk("sw reset load", 32'h43, {24'h0, working_cfg});
    end_test("boot copy");
    host.wr_reg(24'h000012, 8'h5A);
    chk("unmapped write", 32'h43, {24'h0, working_cfg});
    chk("unmapped boot", 32'h43, {24'h0, boot_cfg});
    host.rd_reg(24'h000012, rd_byte, rd_oe);
    chk("unmapped read", 32'h00, {24'h0, rd_byte});
    end_test("unmapped");
    for (int c = 0; c < 4; c++) wrap_case(bwc_pkg::QUAD_RD_CMD, 1'b1, c[1:0], 1'b0, 1'b1);
    wrap_case(bwc_pkg::DDR_QUAD_RD_CMD, 1'b1, 2'h1, 1'b0, 1'b1);
    wrap_case(8'h3C, 1'b1, 2'h1, 1'b0, 1'b0);
    wrap_case(bwc_pkg::QUAD_RD_CMD, 1'b0, 2'h2, 1'b0, 1'b0);
    wrap_case(bwc_pkg::QUAD_RD_CMD, 1'b1, 2'h3, 1'b1, 1'b0);
    end_test("wrap");
    // clock enable low must freeze the working copy against a software reset
    @(posedge clk);
    ce         <= 1'b0;
    sw_reset_i <= 1'b1;
    repeat (2) @(posedge clk);
    sw_reset_i <= 1'b0;
    ce         <= 1'b1;
    #1;
    chk("frozen sw reset", 32'h53, {24'h0, working_cfg});
    end_test("clock enable");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("hw reset boot", 32'h10, {24'h0, boot_cfg});
    chk("hw reset working", 32'h10, {24'h0, working_cfg});
    end_test("hardware reset");
    stop_test();
  end
endmodule : test_burst_wrap_config_register
`default_nettype wire
